// [gpst_periph.sv]
// Purpose: Far-side peripheral that counts the latch and write pulses it receives.
// Assumes: Strobes are active high and return low between bus cycles.
// Notes: Counts wrap at 256, which is far beyond one run.
`timescale 1ns/1ns
module gpst_periph (
	input wire logic clk, // Bus clock.
	input wire logic rstn, // Reset, active low.
	input wire logic io_write_strobe, // I/O write strobe.
	input wire logic memory_write_strobe, // Memory write strobe.
	input wire logic address_latch_strobe, // Address latch strobe.
	output logic [7:0] latch_count, // Latch pulses seen.
	output logic [7:0] write_count // Write pulses seen.
);
	logic prev_ale, prev_wr;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_ale <= 0;
			prev_wr <= 0;
			latch_count <= 8'h00;
			write_count <= 8'h00;
		end else begin
			prev_ale <= address_latch_strobe;
			prev_wr <= io_write_strobe | memory_write_strobe;
			latch_count <= latch_count + 8'(address_latch_strobe & !prev_ale);
			write_count <= write_count + 8'((io_write_strobe | memory_write_strobe) & !prev_wr);
		end
	end
endmodule

// [gpst_pkg.sv]
// Purpose: Constants for the general-purpose bus write and latch strobe timing block.
// Assumes: Byte-wide configuration registers in the memory-mapped configuration region.
// Notes: Offsets are byte offsets within that region.
package gpst_pkg;
	localparam int unsigned GPST_FIELD_W = 8;
	localparam int unsigned GPST_ADDR_W = 12;
	localparam logic [11:0] GPST_WR_OFF_ADDR = 12'h0c0e;
	localparam logic [11:0] GPST_ALE_W_ADDR = 12'h0c0f;
	localparam logic [11:0] GPST_ALE_OFF_ADDR = 12'h0c10;
	localparam logic [7:0] GPST_WR_OFF_RST = 8'h00;
	localparam logic [7:0] GPST_ALE_W_RST = 8'h00;
	localparam logic [7:0] GPST_ALE_OFF_RST = 8'h00;
	localparam int unsigned GPST_CLK_MHZ = 33;
	typedef enum logic [1:0] {GPST_IDLE, GPST_WAIT, GPST_ON, GPST_DONE} gpst_state_t;
endpackage

// [gpst_strobe.sv]
// Purpose: One strobe placed by offset and width counts within a bus cycle.
// Assumes: Start is a one-cycle pulse; stop ends the bus cycle.
// Notes: Strobe rises offset+1 clocks after start and lasts width+1 clocks.
`timescale 1ns/1ns
module gpst_strobe #(
	parameter int unsigned W = 8
) (
	input wire logic clk, // Clock.
	input wire logic rstn, // Reset, active low.
	input wire logic ce, // Clock enable.
	input wire logic start, // Bus-cycle start pulse.
	input wire logic stop, // Bus-cycle end pulse.
	input wire logic [W-1:0] delay, // Offset field.
	input wire logic [W-1:0] len, // Width field.
	output logic strobe // Strobe, active high, registered.
);
	gpst_pkg::gpst_state_t state, next_state;
	logic [W-1:0] cnt, next_cnt;
	logic next_strobe;

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_strobe = 1'b0;
		case (state)
			gpst_pkg::GPST_IDLE: begin
				if (start) begin
					next_state = gpst_pkg::GPST_WAIT;
					next_cnt = delay;
				end
			end
			gpst_pkg::GPST_WAIT: begin
				if (cnt == '0) begin
					next_state = gpst_pkg::GPST_ON;
					next_cnt = len;
					next_strobe = 1'b1;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			gpst_pkg::GPST_ON: begin
				if (cnt == '0) begin
					next_state = gpst_pkg::GPST_DONE;
				end else begin
					next_cnt = cnt - 1'b1;
					next_strobe = 1'b1;
				end
			end
			gpst_pkg::GPST_DONE: begin
				next_state = gpst_pkg::GPST_DONE;
			end
			default: begin
				next_state = gpst_pkg::GPST_IDLE;
			end
		endcase
		if (stop) begin
			next_state = gpst_pkg::GPST_IDLE;
			next_strobe = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= gpst_pkg::GPST_IDLE;
			cnt <= '0;
			strobe <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			cnt <= next_cnt;
			strobe <= next_strobe;
		end
	end
endmodule

// [gpst_timing.sv]
// Purpose: Write strobe and address latch strobe timing for the general-purpose bus.
// Assumes: Bus-cycle start and end pulses come from the chip-select timing logic.
// Notes: One clock is one internal bus clock period.
// Contract
// - Write strobes rise write_delay_field plus one clocks after cycle start; here the output register makes it plus two.
// - One write offset serves both the I/O and memory write strobes.
// - Address latch strobe lasts latch_pulse_len_field plus one clocks.
// - Address latch strobe rises latch_delay_field plus one clocks after cycle start; here the output register makes it plus two.
// - All offsets and widths count whole internal clock periods.
// - Latch offset is measured from the same bus-cycle start as others.
`timescale 1ns/1ns
module gpst_timing #(
	parameter int unsigned FIELD_W = gpst_pkg::GPST_FIELD_W,
	parameter int unsigned WR_WIDTH_W = gpst_pkg::GPST_FIELD_W
) (
	input wire logic clk, // Internal bus clock.
	input wire logic rstn, // Reset, active low.
	input wire logic ce, // Clock enable.
	input wire logic cycle_start, // Bus-cycle start pulse.
	input wire logic cycle_end, // Bus-cycle end pulse.
	input wire logic cycle_is_io, // High for an I/O cycle.
	input wire logic cycle_is_write, // High for a write cycle.
	input wire logic [WR_WIDTH_W-1:0] write_strobe_pulse_len, // Write width field.
	input wire logic [11:0] reg_addr, // Configuration byte offset.
	input wire logic reg_wr, // Register write strobe.
	input wire logic reg_rd, // Register read strobe.
	input wire logic [7:0] reg_wdata, // Write data.
	output logic [7:0] reg_rdata, // Read data, registered.
	output logic io_write_strobe, // I/O write strobe.
	output logic memory_write_strobe, // Memory write strobe.
	output logic address_latch_strobe // Address latch strobe.
);
	// ******************************
	// Registers
	// ******************************
	logic [FIELD_W-1:0] write_strobe_offset, next_write_strobe_offset;
	logic [FIELD_W-1:0] latch_strobe_width, next_latch_strobe_width;
	logic [FIELD_W-1:0] latch_strobe_offset, next_latch_strobe_offset;
	logic [7:0] next_reg_rdata;
	logic wr_raw, ale_raw, is_io, is_wr, next_is_io, next_is_wr;
	logic next_io_wr, next_mem_wr;
	logic cycle_open, next_cycle_open, new_cycle;

	always_comb begin
		next_write_strobe_offset = write_strobe_offset;
		next_latch_strobe_width = latch_strobe_width;
		next_latch_strobe_offset = latch_strobe_offset;
		next_reg_rdata = 8'h00;
		if (reg_wr) begin
			case (reg_addr)
				gpst_pkg::GPST_WR_OFF_ADDR: next_write_strobe_offset = reg_wdata[FIELD_W-1:0];
				gpst_pkg::GPST_ALE_W_ADDR: next_latch_strobe_width = reg_wdata[FIELD_W-1:0];
				gpst_pkg::GPST_ALE_OFF_ADDR: next_latch_strobe_offset = reg_wdata[FIELD_W-1:0];
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				gpst_pkg::GPST_WR_OFF_ADDR: next_reg_rdata = 8'(write_strobe_offset);
				gpst_pkg::GPST_ALE_W_ADDR: next_reg_rdata = 8'(latch_strobe_width);
				gpst_pkg::GPST_ALE_OFF_ADDR: next_reg_rdata = 8'(latch_strobe_offset);
				default: next_reg_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			write_strobe_offset <= gpst_pkg::GPST_WR_OFF_RST;
			latch_strobe_width <= gpst_pkg::GPST_ALE_W_RST;
			latch_strobe_offset <= gpst_pkg::GPST_ALE_OFF_RST;
			reg_rdata <= 8'h00;
		end else if (ce) begin
			write_strobe_offset <= next_write_strobe_offset;
			latch_strobe_width <= next_latch_strobe_width;
			latch_strobe_offset <= next_latch_strobe_offset;
			reg_rdata <= next_reg_rdata;
		end
	end

	// ******************************
	// Strobe generators
	// ******************************
	// Both generators start from the same accepted start, so all offsets share one origin.
	assign new_cycle = cycle_start & ~cycle_open;
	gpst_strobe #(.W(FIELD_W)) u_wr (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.start(new_cycle & cycle_is_write),
		.stop(cycle_end),
		.delay(write_strobe_offset),
		.len(write_strobe_pulse_len[FIELD_W-1:0]),
		.strobe(wr_raw)
	);

	gpst_strobe #(.W(FIELD_W)) u_ale (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.start(new_cycle),
		.stop(cycle_end),
		.delay(latch_strobe_offset),
		.len(latch_strobe_width),
		.strobe(ale_raw)
	);

	always_comb begin
		next_is_io = is_io;
		next_is_wr = is_wr;
		next_cycle_open = cycle_open;
		if (new_cycle) begin
			next_is_io = cycle_is_io;
			next_is_wr = cycle_is_write;
		end
		// A start inside an open cycle is refused, so no strobe can restart and the
		// cycle type cannot change under a strobe that is still running.
		if (cycle_end) begin
			next_cycle_open = 1'b0;
		end else if (cycle_start) begin
			next_cycle_open = 1'b1;
		end
		// The type is latched at start so a late change cannot split the strobe.
		next_io_wr = wr_raw & is_io;
		next_mem_wr = wr_raw & ~is_io;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			is_io <= 1'b0;
			is_wr <= 1'b0;
			cycle_open <= 1'b0;
			io_write_strobe <= 1'b0;
			memory_write_strobe <= 1'b0;
			address_latch_strobe <= 1'b0;
		end else if (ce) begin
			is_io <= next_is_io;
			is_wr <= next_is_wr;
			cycle_open <= next_cycle_open;
			io_write_strobe <= next_io_wr;
			memory_write_strobe <= next_mem_wr;
			address_latch_strobe <= ale_raw;
		end
	end

	// ******************************
	// Check helpers
	// ******************************
	// Clocks since the edge that opened the cycle, and the offsets that were loaded then.
	// Holding the offsets keeps a register write inside a cycle from tripping the checks.
	logic [FIELD_W+1:0] since_start, next_since_start;
	logic [FIELD_W-1:0] ale_off_used, next_ale_off_used;
	logic [FIELD_W-1:0] wr_off_used, next_wr_off_used;

	always_comb begin
		next_since_start = since_start;
		next_ale_off_used = ale_off_used;
		next_wr_off_used = wr_off_used;
		if (new_cycle) begin
			next_since_start = '0;
			next_ale_off_used = latch_strobe_offset;
			next_wr_off_used = write_strobe_offset;
		end else if (since_start != '1) begin
			next_since_start = since_start + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			since_start <= '0;
			ale_off_used <= '0;
			wr_off_used <= '0;
		end else if (ce) begin
			since_start <= next_since_start;
			ale_off_used <= next_ale_off_used;
			wr_off_used <= next_wr_off_used;
		end
	end

	// ******************************
	// Checks
	// ******************************
	sequence ale_start_s;
		cycle_start && ce && !cycle_end && !cycle_open;
	endsequence

	ale_zero_off_a: assert property (@(posedge clk) disable iff (!rstn)
		ale_start_s ##0 (latch_strobe_offset == 8'h00) ##1 (ce && !cycle_end)[*2]
		|=> address_latch_strobe)
		else $error("latch strobe late for zero offset");

	ale_not_early_a: assert property (@(posedge clk) disable iff (!rstn)
		ale_start_s |=> !address_latch_strobe)
		else $error("latch strobe before offset");

	wr_one_kind_a: assert property (@(posedge clk) disable iff (!rstn)
		!(io_write_strobe && memory_write_strobe))
		else $error("both write strobes active");

	ale_one_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(address_latch_strobe) && latch_strobe_width == 8'h00 && ce |=> !address_latch_strobe)
		else $error("latch strobe wider than one clock");

	wr_needs_write_a: assert property (@(posedge clk) disable iff (!rstn)
		(io_write_strobe || memory_write_strobe) |-> is_wr)
		else $error("write strobe outside write cycle");

	ale_no_restart_a: assert property (@(posedge clk) disable iff (!rstn)
		$fell(address_latch_strobe) && cycle_open && $past(cycle_open)
		|=> !address_latch_strobe[*2])
		else $error("latch strobe restarted");

	wr_zero_off_a: assert property (@(posedge clk) disable iff (!rstn)
		ale_start_s ##0 (cycle_is_write && write_strobe_offset == 8'h00)
		##1 (ce && !cycle_end)[*2] |=> (io_write_strobe || memory_write_strobe))
		else $error("write strobe late for zero offset");

	end_clears_a: assert property (@(posedge clk) disable iff (!rstn)
		cycle_end && ce ##1 ce |=> !address_latch_strobe)
		else $error("latch strobe survives cycle end");

	ale_offset_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(address_latch_strobe) |-> since_start == ale_off_used + 2)
		else $error("latch strobe offset wrong");

	wr_offset_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(io_write_strobe || memory_write_strobe) |-> since_start == wr_off_used + 2)
		else $error("write strobe offset wrong");

	io_routing_a: assert property (@(posedge clk) disable iff (!rstn)
		io_write_strobe |-> is_io)
		else $error("I/O write strobe in a memory cycle");
endmodule

// [tb.sv]
// Purpose: Self-checking bench for the write and latch strobe timing block.
// Assumes: Clock enable high except in one freeze check; strobes are sampled at the falling edge.
// Notes: Strobe windows are counted in edges from the edge that takes the start.
`timescale 1ns/1ns
module tb;
	logic clk = 0, rstn = 0, ce = 1, cs = 0, cend = 0, is_io = 0, is_wr = 0, rd = 0, wr = 0;
	logic [7:0] wlen = 8'h00, wdata = 8'h00, rdata, ale_seen, wr_seen;
	logic [11:0] addr = 12'h000;
	logic io_s, mem_s, ale_s;
	logic [7:0] lfsr = 8'h2f;
	int fails = 0, tests_run = 0, cyc = 0, ale_n = 0, wr_n = 0, woff, wl, aw, aoff;
	gpst_timing i_gpst_timing (.clk(clk), .rstn(rstn), .ce(ce), .cycle_start(cs),
		.cycle_end(cend), .cycle_is_io(is_io), .cycle_is_write(is_wr),
		.write_strobe_pulse_len(wlen), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
		.reg_wdata(wdata), .reg_rdata(rdata), .io_write_strobe(io_s),
		.memory_write_strobe(mem_s), .address_latch_strobe(ale_s));
	gpst_periph i_gpst_periph (.clk(clk), .rstn(rstn), .io_write_strobe(io_s),
		.memory_write_strobe(mem_s), .address_latch_strobe(ale_s),
		.latch_count(ale_seen), .write_count(wr_seen));
	initial forever #4 clk = ~clk;
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic conclude();
		if (fails == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			conclude();
		end
	end
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic reg_check(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		@(negedge clk);
		chk("reg_rdata", exp, rdata);
	endtask
	// The cycle is held open past the last strobe, as software must arrange.
	task automatic bus_cycle(input logic io, input logic w, input bit restart);
		int len;
		logic a_on, w_on;
		len = (woff + wl > aoff + aw ? woff + wl : aoff + aw) + 4;
		@(posedge clk);
		cs <= 1;
		is_io <= io;
		is_wr <= w;
		for (int k = 0; k <= len; k++) begin
			@(posedge clk);
			cs <= restart && k == 3;
			@(negedge clk);
			a_on = k >= aoff + 2 && k <= aoff + aw + 2;
			w_on = w && k >= woff + 2 && k <= woff + wl + 2;
			chk("strobes", {5'h0, a_on, w_on & io, w_on & !io}, {5'h0, ale_s, io_s, mem_s});
		end
		ale_n++;
		wr_n += w;
		@(posedge clk);
		cend <= 1;
		@(posedge clk);
		cend <= 0;
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1;
		reg_check(gpst_pkg::GPST_WR_OFF_ADDR, gpst_pkg::GPST_WR_OFF_RST);
		reg_check(gpst_pkg::GPST_ALE_W_ADDR, gpst_pkg::GPST_ALE_W_RST);
		reg_check(gpst_pkg::GPST_ALE_OFF_ADDR, gpst_pkg::GPST_ALE_OFF_RST);
		for (int n = 0; n < 12; n++) begin
			woff = n < 2 ? 255 * n : rnd() % 16;
			wl = n < 2 ? 255 * n : rnd() % 16;
			aw = n < 2 ? 255 * n : rnd() % 16;
			aoff = n < 2 ? 255 * n : rnd() % 16;
			wlen <= wl[7:0];
			reg_write(gpst_pkg::GPST_WR_OFF_ADDR, woff[7:0]);
			reg_write(gpst_pkg::GPST_ALE_W_ADDR, aw[7:0]);
			reg_write(gpst_pkg::GPST_ALE_OFF_ADDR, aoff[7:0]);
			reg_check(gpst_pkg::GPST_WR_OFF_ADDR, woff[7:0]);
			reg_check(gpst_pkg::GPST_ALE_W_ADDR, aw[7:0]);
			reg_check(gpst_pkg::GPST_ALE_OFF_ADDR, aoff[7:0]);
			bus_cycle(n[0], n[1] | n[2] | (n == 0), n % 3 == 0);
		end
		// A write made while the clock enable is low must not land.
		ce <= 1'b0;
		reg_write(gpst_pkg::GPST_ALE_OFF_ADDR, 8'h5a);
		ce <= 1'b1;
		reg_check(gpst_pkg::GPST_ALE_OFF_ADDR, aoff[7:0]);
		reg_write(12'h0c11, 8'h5a);
		reg_check(12'h0c11, 8'h00);
		@(negedge clk);
		chk("strobes_idle", 8'h00, {5'h0, ale_s, io_s, mem_s});
		chk("latch_count", ale_n[7:0], ale_seen);
		chk("write_count", wr_n[7:0], wr_seen);
		conclude();
	end
endmodule
